// [rtl/oscs_consts.vh]
// Register indices, field positions, reset values and counts
// for the oscillator control and status block.
// Assumes byte address = 4 * index on a 32-bit APB.
`ifndef OSCS_CONSTS_VH
`define OSCS_CONSTS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define OSCS_IDX_STATUS 8'h03
`define OSCS_IDX_KEY 8'h04
`define OSCS_IDX_FCTRL 8'h10
`define OSCS_IDX_FTRIM 8'h11
`define OSCS_IDX_FTEMP 8'h12
`define OSCS_IDX_SCTRL 8'h18
`define OSCS_IDX_XCTRL 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OSCS_BIT_RUNSTBY 1
`define OSCS_BIT_XEN 0
`define OSCS_BIT_XRUN 1
`define OSCS_BIT_XSEL 2
`define OSCS_BIT_CRYSTAL_STARTUP_COUNT 4
`define OSCS_BIT_LOCK 7
`define OSCS_BIT_SW 0
`define OSCS_BIT_FSTB 4
`define OSCS_BIT_SSTB 5
`define OSCS_BIT_XSTB 6
`define OSCS_BIT_EXTS 7

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define OSCS_RST_CTRL 8'h00
`define OSCS_UNLOCK_KEY 8'hA5
`define OSCS_UNLOCK_SPAN 3'h4
`define OSCS_GATE_INT 3'h4
`define OSCS_GATE_XTAL 3'h2
`define OSCS_CRYSTAL_STARTUP_COUNT_1K 17'h00400
`define OSCS_CRYSTAL_STARTUP_COUNT_16K 17'h04000
`define OSCS_CRYSTAL_STARTUP_COUNT_32K 17'h08000
`define OSCS_CRYSTAL_STARTUP_COUNT_64K 17'h10000
`define OSCS_INT_SUT 17'h00010

`endif

// [rtl/oscs_unlock.v]
// Unlock window for protected register writes.
// Assumes single-cycle pulses from the APB slave on pclk.
`timescale 1ns/1ps
`default_nettype none

module oscs_unlock (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Bus events
    input wire key_hit,
    input wire xfer_done,
    input wire prot_write,
    // Window state
    output wire unlocked
);
`include "oscs_consts.vh"

reg [2:0] left_reg;

// ----------------------------------------
// Window counter
// ----------------------------------------
// A fresh key wins over any other event in the same cycle.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        left_reg <= 3'h0;
    end else if (key_hit) begin
        left_reg <= `OSCS_UNLOCK_SPAN;
    end else if (prot_write) begin
        left_reg <= 3'h0;
    end else if (xfer_done && left_reg != 3'h0) begin
        left_reg <= left_reg - 3'h1;
    end
end

assign unlocked = (left_reg != 3'h0);

endmodule // oscs_unlock

`default_nettype wire

// [rtl/oscs_gate.v]
// Start-up counter and glitch-free output gate for one oscillator.
// Assumes osc_in is asynchronous to pclk and much slower than it.
`timescale 1ns/1ps
`default_nettype none

module oscs_gate #(
    parameter CW = 17,
    parameter [2:0] GATE_CYC = 3'h4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Oscillator side
    input wire osc_in,
    input wire power,
    input wire req,
    input wire [CW-1:0] startup,
    // Results
    output wire clk_out,
    output wire warm,
    output wire gate_open
);

reg s1_reg;
reg s2_reg;
reg s3_reg;
reg [CW-1:0] wcnt_reg;
reg warm_reg;
reg [2:0] gcnt_reg;
reg gate_reg;
reg out_reg;
wire rise;

assign rise = s2_reg & ~s3_reg;

// ----------------------------------------
// Synchroniser, start-up and gate
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        wcnt_reg <= {CW{1'b0}};
        warm_reg <= 1'b0;
        gcnt_reg <= 3'h0;
        gate_reg <= 1'b0;
        out_reg <= 1'b0;
    end else begin
        s1_reg <= osc_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (!power) begin
            wcnt_reg <= {CW{1'b0}};
            warm_reg <= 1'b0;
        end else if (!warm_reg) begin
            if (wcnt_reg >= startup)
                warm_reg <= 1'b1;
            else if (rise)
                wcnt_reg <= wcnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end
        if (!req || !warm_reg)
            gcnt_reg <= 3'h0;
        else if (rise && gcnt_reg != GATE_CYC)
            gcnt_reg <= gcnt_reg + 3'h1;
        // Switching while low keeps pulses whole; a power loss closes the gate at any level.
        if (!power)
            gate_reg <= 1'b0;
        else if (!s2_reg)
            gate_reg <= req & warm_reg & (gcnt_reg == GATE_CYC);
        out_reg <= s2_reg & gate_reg;
    end
end

assign clk_out = out_reg;
assign warm = warm_reg;
assign gate_open = gate_reg;

endmodule // oscs_gate

`default_nettype wire

// [rtl/oscs_top.v]
// Oscillator control, calibration and status registers on APB.
// Assumes oscillator outputs and the crystal pin arrive asynchronously;
// requests, fuses and the main clock select come from pclk logic.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "oscs_consts.vh"

module oscs_top #(
    parameter AW = 12,
    parameter [16:0] CRYSTAL_STARTUP_COUNT_1K = `OSCS_CRYSTAL_STARTUP_COUNT_1K,
    parameter [16:0] CRYSTAL_STARTUP_COUNT_16K = `OSCS_CRYSTAL_STARTUP_COUNT_16K,
    parameter [16:0] CRYSTAL_STARTUP_COUNT_32K = `OSCS_CRYSTAL_STARTUP_COUNT_32K,
    parameter [16:0] CRYSTAL_STARTUP_COUNT_64K = `OSCS_CRYSTAL_STARTUP_COUNT_64K,
    parameter [16:0] FAST_SUT = `OSCS_INT_SUT,
    parameter [16:0] SLOW_SUT = `OSCS_INT_SUT,
    parameter [5:0] TRIM_16M = 6'h20,
    parameter [5:0] TRIM_20M = 6'h20,
    parameter [3:0] SLOPE_16M = 4'h8,
    parameter [3:0] SLOPE_20M = 4'h8
) (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Fuses
    input wire fuse_freq_choice,
    input wire fuse_calib_lock,
    // Main clock select logic
    input wire [1:0] main_src_sel,
    input wire main_switch_start,
    input wire ext_clk_started,
    // Peripheral clock requests
    input wire fast_periph_req,
    input wire slow_periph_req,
    input wire xtal_periph_req,
    // Raw oscillator outputs
    input wire fast_osc_in,
    input wire slow_osc_in,
    input wire crystal_pin_in,
    // Oscillator power and trim
    output wire fast_osc_power,
    output wire slow_osc_power,
    output wire crystal_osc_power,
    output wire [5:0] freq_trim,
    output wire [3:0] temp_slope_trim,
    // Crystal pins
    output wire crystal_pins_owned,
    output wire crystal_ext_mode,
    // Gated clocks
    output wire fast_clk_gated,
    output wire slow_clk_gated,
    output wire crystal_clk_gated,
    // Status
    output wire main_clock_switching
);

// ----------------------------------------
// Declarations
// ----------------------------------------
reg fctrl_run_reg;
reg sctrl_run_reg;
reg [5:0] ftrim_reg;
reg [3:0] ftemp_reg;
reg lock_reg;
reg fuse_done_reg;
reg xen_reg;
reg xrun_reg;
reg xsel_reg;
reg [1:0] crystal_startup_count_reg;
reg sw_reg;
reg [31:0] prdata_reg;
reg mapped;
reg [16:0] xtal_sut;
wire [7:0] idx;
wire upper_zero;
wire setup_ph;
wire acc_ph;
wire wr;
wire key_hit;
wire unlocked;
wire prot_ok;
wire prot_write;
wire fast_req;
wire slow_req;
wire xtal_req;
wire fast_warm;
wire slow_warm;
wire xtal_warm;
wire fast_stable;
wire slow_stable;
wire xtal_stable;
reg target_ok;

// ----------------------------------------
// APB decode
// ----------------------------------------
assign idx = paddr[9:2];
assign upper_zero = (paddr[AW-1:10] == {(AW-10){1'b0}}) &&
                    (paddr[1:0] == 2'b00);
assign setup_ph = psel & ~penable;
assign acc_ph = psel & penable;
assign pready = 1'b1;
assign pslverr = acc_ph & ~mapped;
assign wr = acc_ph & pwrite & mapped & pstrb[0];
assign prdata = prdata_reg;

always @* begin
    mapped = 1'b0;
    if (upper_zero) begin
        case (idx)
            `OSCS_IDX_STATUS: mapped = 1'b1;
            `OSCS_IDX_KEY: mapped = 1'b1;
            `OSCS_IDX_FCTRL: mapped = 1'b1;
            `OSCS_IDX_FTRIM: mapped = 1'b1;
            `OSCS_IDX_FTEMP: mapped = 1'b1;
            `OSCS_IDX_SCTRL: mapped = 1'b1;
            `OSCS_IDX_XCTRL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
end

// ----------------------------------------
// Protection window
// ----------------------------------------
assign key_hit = wr && (idx == `OSCS_IDX_KEY) &&
                 (pwdata[7:0] == `OSCS_UNLOCK_KEY);
assign prot_ok = unlocked & fuse_done_reg;
assign prot_write = wr && prot_ok && (idx != `OSCS_IDX_KEY) &&
                    (idx != `OSCS_IDX_STATUS);

oscs_unlock u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .key_hit(key_hit),
    .xfer_done(acc_ph),
    .prot_write(prot_write),
    .unlocked(unlocked)
);

// ----------------------------------------
// Control registers
// ----------------------------------------
// Fuse levels are caught on the first edge after reset release, never
// by the asynchronous reset itself.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fctrl_run_reg <= 1'b0;
        sctrl_run_reg <= 1'b0;
        ftrim_reg <= 6'h00;
        ftemp_reg <= 4'h0;
        lock_reg <= 1'b0;
        fuse_done_reg <= 1'b0;
        xen_reg <= 1'b0;
        xrun_reg <= 1'b0;
        xsel_reg <= 1'b0;
        crystal_startup_count_reg <= 2'b00;
    end else if (!fuse_done_reg) begin
        fuse_done_reg <= 1'b1;
        ftrim_reg <= fuse_freq_choice ? TRIM_20M : TRIM_16M;
        ftemp_reg <= fuse_freq_choice ? SLOPE_20M : SLOPE_16M;
        lock_reg <= fuse_calib_lock;
    end else if (prot_write) begin
        case (idx)
            `OSCS_IDX_FCTRL:
                fctrl_run_reg <= pwdata[`OSCS_BIT_RUNSTBY];
            `OSCS_IDX_FTRIM:
                if (!lock_reg)
                    ftrim_reg <= pwdata[5:0];
            `OSCS_IDX_FTEMP:
                if (!lock_reg)
                    ftemp_reg <= pwdata[3:0];
            `OSCS_IDX_SCTRL:
                sctrl_run_reg <= pwdata[`OSCS_BIT_RUNSTBY];
            `OSCS_IDX_XCTRL: begin
                xen_reg <= pwdata[`OSCS_BIT_XEN];
                xrun_reg <= pwdata[`OSCS_BIT_XRUN];
                if (!xen_reg && !xtal_stable) begin
                    xsel_reg <= pwdata[`OSCS_BIT_XSEL];
                    crystal_startup_count_reg <= pwdata[`OSCS_BIT_CRYSTAL_STARTUP_COUNT+1:`OSCS_BIT_CRYSTAL_STARTUP_COUNT];
                end
            end
            default: ;
        endcase
    end
end

// ----------------------------------------
// Requests and power
// ----------------------------------------
assign fast_req = fast_periph_req | (main_src_sel == 2'b00);
assign slow_req = slow_periph_req | (main_src_sel == 2'b01);
assign xtal_req = xtal_periph_req | (main_src_sel == 2'b10);

assign fast_osc_power = fctrl_run_reg | fast_req;
assign slow_osc_power = sctrl_run_reg | slow_req;
assign crystal_osc_power = xen_reg & (xrun_reg | xtal_req);

// The enable alone decides pin ownership, so the pins are held even
// while the oscillator idles waiting for a request.
assign crystal_pins_owned = xen_reg;
assign crystal_ext_mode = xsel_reg;
assign freq_trim = ftrim_reg;
assign temp_slope_trim = ftemp_reg;

always @* begin
    case (crystal_startup_count_reg)
        2'b00: xtal_sut = CRYSTAL_STARTUP_COUNT_1K;
        2'b01: xtal_sut = CRYSTAL_STARTUP_COUNT_16K;
        2'b10: xtal_sut = CRYSTAL_STARTUP_COUNT_32K;
        2'b11: xtal_sut = CRYSTAL_STARTUP_COUNT_64K;
        default: xtal_sut = CRYSTAL_STARTUP_COUNT_64K;
    endcase
    if (xsel_reg)
        xtal_sut = 17'h00000;
end

// ----------------------------------------
// Oscillator gates
// ----------------------------------------
oscs_gate #(
    .CW(17),
    .GATE_CYC(`OSCS_GATE_INT)
) u_fast (
    .pclk(pclk),
    .presetn(presetn),
    .osc_in(fast_osc_in),
    .power(fast_osc_power),
    .req(fast_req),
    .startup(FAST_SUT),
    .clk_out(fast_clk_gated),
    .warm(fast_warm),
    .gate_open()
);

oscs_gate #(
    .CW(17),
    .GATE_CYC(`OSCS_GATE_INT)
) u_slow (
    .pclk(pclk),
    .presetn(presetn),
    .osc_in(slow_osc_in),
    .power(slow_osc_power),
    .req(slow_req),
    .startup(SLOW_SUT),
    .clk_out(slow_clk_gated),
    .warm(slow_warm),
    .gate_open()
);

// A short gate count is what makes a warm crystal answer quickly.
oscs_gate #(
    .CW(17),
    .GATE_CYC(`OSCS_GATE_XTAL)
) u_xtal (
    .pclk(pclk),
    .presetn(presetn),
    .osc_in(crystal_pin_in),
    .power(crystal_osc_power),
    .req(xtal_req),
    .startup(xtal_sut),
    .clk_out(crystal_clk_gated),
    .warm(xtal_warm),
    .gate_open()
);

// ----------------------------------------
// Status
// ----------------------------------------
assign fast_stable = fast_warm & fast_req;
assign slow_stable = slow_warm & slow_req;
assign xtal_stable = xtal_warm & xtal_req;

always @* begin
    case (main_src_sel)
        2'b00: target_ok = fast_stable;
        2'b01: target_ok = slow_stable;
        2'b10: target_ok = xtal_stable;
        default: target_ok = ext_clk_started;
    endcase
end

// A new switch request in the clearing cycle keeps the flag set.
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        sw_reg <= 1'b0;
    else if (main_switch_start)
        sw_reg <= 1'b1;
    else if (target_ok)
        sw_reg <= 1'b0;
end
assign main_clock_switching = sw_reg;

// ----------------------------------------
// Read data
// ----------------------------------------
// Read data is loaded in the setup cycle, so no wait states are needed.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_reg <= 32'h00000000;
    end else if (setup_ph) begin
        prdata_reg <= 32'h00000000;
        if (upper_zero && !pwrite) begin
            case (idx)
                `OSCS_IDX_STATUS: begin
                    prdata_reg[`OSCS_BIT_SW] <= sw_reg;
                    prdata_reg[`OSCS_BIT_FSTB] <= fast_stable;
                    prdata_reg[`OSCS_BIT_SSTB] <= slow_stable;
                    prdata_reg[`OSCS_BIT_XSTB] <= xtal_stable;
                    prdata_reg[`OSCS_BIT_EXTS] <= ext_clk_started;
                end
                `OSCS_IDX_FCTRL:
                    prdata_reg[`OSCS_BIT_RUNSTBY] <= fctrl_run_reg;
                `OSCS_IDX_FTRIM:
                    prdata_reg[5:0] <= ftrim_reg;
                `OSCS_IDX_FTEMP: begin
                    prdata_reg[3:0] <= ftemp_reg;
                    prdata_reg[`OSCS_BIT_LOCK] <= lock_reg;
                end
                `OSCS_IDX_SCTRL:
                    prdata_reg[`OSCS_BIT_RUNSTBY] <= sctrl_run_reg;
                `OSCS_IDX_XCTRL: begin
                    prdata_reg[`OSCS_BIT_XEN] <= xen_reg;
                    prdata_reg[`OSCS_BIT_XRUN] <= xrun_reg;
                    prdata_reg[`OSCS_BIT_XSEL] <= xsel_reg;
                    prdata_reg[`OSCS_BIT_CRYSTAL_STARTUP_COUNT+1:`OSCS_BIT_CRYSTAL_STARTUP_COUNT] <= crystal_startup_count_reg;
                end
                default: ;
            endcase
        end
    end
end

endmodule // oscs_top

`default_nettype wire

// [tb/oscs_top_chk.sv]
// Port-level checker for oscs_top, bound into every instance of it.
// Assumes one pclk domain with presetn asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module oscs_top_chk #(
    parameter AW = 12
) (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic pslverr,
    // Fuses, main clock and requests
    input wire logic fuse_calib_lock,
    input wire logic [1:0] main_src_sel,
    input wire logic main_switch_start,
    input wire logic ext_clk_started,
    input wire logic fast_periph_req,
    // Block outputs
    input wire logic fast_osc_power,
    input wire logic crystal_osc_power,
    input wire logic [5:0] freq_trim,
    input wire logic crystal_pins_owned,
    input wire logic crystal_ext_mode,
    input wire logic fast_clk_gated,
    input wire logic main_clock_switching
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic fast_want = fast_periph_req || main_src_sel == 2'h0;
    sequence s_fast_idle;
        !fast_want [*8];
    endsequence
    sequence s_kick;
        main_switch_start;
    endsequence
    // Two edges after reset the fuse load still shows as a change, so it is excluded.
    property p_unmapped;
        acc && !(paddr[9:2] inside {8'h03, 8'h04, 8'h10, 8'h11, 8'h12, 8'h18, 8'h1C}) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_xpow; crystal_osc_power |-> crystal_pins_owned; endproperty
    a_xpow: assert property (p_xpow) else $error("crystal powered while disabled");
    property p_fpow; fast_periph_req || main_src_sel == 2'h0 |-> fast_osc_power; endproperty
    a_fpow: assert property (p_fpow) else $error("fast oscillator unpowered");
    property p_gate_off; s_fast_idle |-> !fast_clk_gated; endproperty
    a_gate_off: assert property (p_gate_off) else $error("fast clock without request");
    property p_gate_on; $rose(fast_clk_gated) |-> $past(fast_want, 8); endproperty
    a_gate_on: assert property (p_gate_on) else $error("fast gate opened early");
    property p_sw_set; s_kick |=> main_clock_switching; endproperty
    a_sw_set: assert property (p_sw_set) else $error("switch flag not set");
    property p_sw_clr;
        main_clock_switching && main_src_sel == 2'h3 && ext_clk_started && !main_switch_start
            |-> ##[1:2] !main_clock_switching;
    endproperty
    a_sw_clr: assert property (p_sw_clr) else $error("switch flag not cleared");
    property p_trim_wr;
        $changed(freq_trim) && $past(presetn, 2) |-> $past(acc && pwrite && paddr[9:2] == 8'h11);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim moved without write");
    property p_lock; fuse_calib_lock && $past(presetn, 2) |-> $stable(freq_trim); endproperty
    a_lock: assert property (p_lock) else $error("locked trim changed");
    property p_sel_lock;
        $changed(crystal_ext_mode) && $past(presetn, 2)
            |-> $past(acc && pwrite && paddr[9:2] == 8'h1C && !crystal_pins_owned);
    endproperty
    a_sel_lock: assert property (p_sel_lock) else $error("select changed while enabled");
endmodule // oscs_top_chk
bind oscs_top oscs_top_chk #(.AW(AW)) oscs_top_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
    .fuse_calib_lock(fuse_calib_lock), .main_src_sel(main_src_sel),
    .main_switch_start(main_switch_start), .ext_clk_started(ext_clk_started),
    .fast_periph_req(fast_periph_req), .fast_osc_power(fast_osc_power),
    .crystal_osc_power(crystal_osc_power), .freq_trim(freq_trim),
    .crystal_pins_owned(crystal_pins_owned), .crystal_ext_mode(crystal_ext_mode),
    .fast_clk_gated(fast_clk_gated), .main_clock_switching(main_clock_switching));
`default_nettype wire

// [tb/oscs_osc_model.sv]
// Stand-in for the 32.768 kHz crystal or a raw internal oscillator.
// Assumes power comes from the block; a stopped oscillator rests low.
`timescale 1ns/1ps
`default_nettype none
module oscs_osc_model #(
    parameter int HALF = 130
) (
    // Power from the block
    input wire logic power,
    // Oscillator output
    output logic clk
);
    initial begin
        clk = 1'b0;
        forever begin
            #(HALF);
            clk = power ? ~clk : 1'b0;
        end
    end
endmodule // oscs_osc_model
`default_nettype wire

// [tb/tb_oscillator_control_status.sv]
// Bench for oscs_top: APB master, oscillator stand-ins and a read scoreboard.
// Assumes the checker binds itself; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_oscillator_control_status;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic fuse_freq_choice, fuse_calib_lock, main_switch_start, ext_clk_started;
    logic fast_periph_req, slow_periph_req, xtal_periph_req;
    logic [1:0] main_src_sel;
    wire [31:0] prdata;
    wire pready, pslverr, fast_osc_in, slow_osc_in, crystal_pin_in;
    wire fast_osc_power, slow_osc_power, crystal_osc_power, crystal_pins_owned, crystal_ext_mode;
    wire fast_clk_gated, slow_clk_gated, crystal_clk_gated, main_clock_switching;
    wire [5:0] freq_trim;
    wire [3:0] temp_slope_trim;
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'h0F2F;
    logic strb0 = 1'b1;
    logic [8:0] exp_q[$];
    oscs_top #(.CRYSTAL_STARTUP_COUNT_64K(17'h00010), .TRIM_16M(6'h15), .TRIM_20M(6'h2A), .SLOPE_16M(4'h3),
        .SLOPE_20M(4'hC)) oscs_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuse_freq_choice(fuse_freq_choice), .fuse_calib_lock(fuse_calib_lock),
        .main_src_sel(main_src_sel), .main_switch_start(main_switch_start),
        .ext_clk_started(ext_clk_started), .fast_periph_req(fast_periph_req),
        .slow_periph_req(slow_periph_req), .xtal_periph_req(xtal_periph_req),
        .fast_osc_in(fast_osc_in), .slow_osc_in(slow_osc_in), .crystal_pin_in(crystal_pin_in),
        .fast_osc_power(fast_osc_power), .slow_osc_power(slow_osc_power),
        .crystal_osc_power(crystal_osc_power), .freq_trim(freq_trim),
        .temp_slope_trim(temp_slope_trim), .crystal_pins_owned(crystal_pins_owned),
        .crystal_ext_mode(crystal_ext_mode), .fast_clk_gated(fast_clk_gated),
        .slow_clk_gated(slow_clk_gated), .crystal_clk_gated(crystal_clk_gated),
        .main_clock_switching(main_clock_switching));
    oscs_osc_model #(.HALF(50)) fast_osc_model_i (.power(fast_osc_power), .clk(fast_osc_in));
    oscs_osc_model #(.HALF(110)) slow_osc_model_i (.power(slow_osc_power), .clk(slow_osc_in));
    oscs_osc_model oscs_osc_model_i (.power(crystal_osc_power), .clk(crystal_pin_in));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic do_reset(input logic fq, input logic lk);
        fuse_freq_choice <= fq;
        fuse_calib_lock <= lk;
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Upper write-data bits are random: only byte 0 may matter.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rnd;
        int k;
        rnd = $random(seed);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {rnd[31:8], d};
        pstrb <= {rnd[31:29], strb0};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [8:0] e);
        exp_q.push_back(e);
        xfer(1'b0, idx, 8'h00);
    endtask

    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic pw(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, 8'h04, 8'hA5);
        xfer(1'b1, idx, d);
    endtask

    task automatic wait_gate(input int lo, input int hi, input logic [2:0] m);
        int k;
        k = 0;
        while (({crystal_clk_gated, slow_clk_gated, fast_clk_gated} & m) === 3'h0 && k < hi) begin
            @(posedge pclk);
            k++;
        end
        comparisons++;
        if (k < lo || k >= hi) begin
            n_errors++;
            $display("[FAIL] gate delay expected %0d to %0d seen %0d", lo, hi, k);
        end
        if (k >= hi) report_and_stop();
    endtask

    always @(posedge pclk) begin
        if (psel && penable && !pwrite && exp_q.size() > 0) begin
            comparisons++;
            if ({pslverr, prdata[7:0]} !== exp_q[0] || prdata[31:8] !== 24'h000000) begin
                n_errors++;
                $display("[FAIL] reg %h expected %h seen %h", paddr[9:2], exp_q[0],
                    {pslverr, prdata[7:0]});
            end
            void'(exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("[FAIL] run expected done seen timeout");
        report_and_stop();
    end

    initial begin
        logic [7:0] r;
        logic fq;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        main_src_sel = 2'h3;
        main_switch_start = 1'b0;
        ext_clk_started = 1'b0;
        fast_periph_req = 1'b0;
        slow_periph_req = 1'b0;
        xtal_periph_req = 1'b0;
        presetn = 1'b0;
        fq = $random(seed);
        do_reset(fq, 1'b0);
        rd(8'h10, 9'h000);
        rd(8'h11, fq ? 9'h02A : 9'h015);
        rd(8'h12, fq ? 9'h00C : 9'h003);
        rd(8'h1C, 9'h000);
        rd(8'h05, 9'h100);
        xfer(1'b1, 8'h10, 8'h02);
        rd(8'h10, 9'h000);
        pw(8'h10, 8'hFF);
        rd(8'h10, 9'h002);
        pw(8'h18, 8'hFF);
        rd(8'h18, 9'h002);
        strb0 = 1'b0;
        pw(8'h18, 8'h00);
        strb0 = 1'b1;
        rd(8'h18, 9'h002);
        cmp("slow_osc_power", 8'h01, {7'h00, slow_osc_power});
        repeat (3) begin
            r = $random(seed);
            pw(8'h11, r);
            rd(8'h11, {3'h0, r[5:0]});
        end
        // The fourth transfer after the key is still inside the window, the fifth is not.
        xfer(1'b1, 8'h04, 8'hA5);
        repeat (3) rd(8'h11, {3'h0, r[5:0]});
        xfer(1'b1, 8'h11, 8'h3F);
        xfer(1'b1, 8'h04, 8'hA5);
        repeat (4) rd(8'h11, 9'h03F);
        xfer(1'b1, 8'h11, 8'h01);
        rd(8'h11, 9'h03F);
        pw(8'h12, 8'hFF);
        xfer(1'b1, 8'h12, 8'h00);
        rd(8'h12, 9'h00F);
        cmp("temp_slope_trim", 8'h0F, {4'h0, temp_slope_trim});
        @(posedge pclk);
        main_switch_start <= 1'b1;
        @(posedge pclk);
        main_switch_start <= 1'b0;
        rd(8'h03, 9'h001);
        ext_clk_started <= 1'b1;
        rd(8'h03, 9'h080);
        fast_periph_req <= 1'b1;
        slow_periph_req <= 1'b1;
        wait_gate(0, 200, 3'b001);
        wait_gate(0, 400, 3'b010);
        rd(8'h03, 9'h0B0);
        fast_periph_req <= 1'b0;
        slow_periph_req <= 1'b0;
        rd(8'h03, 9'h080);
        pw(8'h1C, 8'h31);
        pw(8'h1C, 8'h35);
        rd(8'h1C, 9'h031);
        cmp("crystal_pins_owned", 8'h01, {7'h00, crystal_pins_owned});
        xtal_periph_req <= 1'b1;
        wait_gate(150, 400, 3'b100);
        rd(8'h03, 9'h0C0);
        pw(8'h1C, 8'h00);
        rd(8'h1C, 9'h030);
        xtal_periph_req <= 1'b0;
        rd(8'h03, 9'h080);
        pw(8'h1C, 8'h34);
        pw(8'h1C, 8'h37);
        rd(8'h1C, 9'h037);
        cmp("crystal_ext_mode", 8'h01, {7'h00, crystal_ext_mode});
        rd(8'h03, 9'h080);
        xtal_periph_req <= 1'b1;
        wait_gate(0, 45, 3'b100);
        main_src_sel <= 2'h0;
        main_switch_start <= 1'b1;
        @(posedge pclk);
        main_switch_start <= 1'b0;
        rd(8'h03, 9'h0D0);
        do_reset(~fq, 1'b1);
        rd(8'h11, fq ? 9'h015 : 9'h02A);
        rd(8'h12, fq ? 9'h083 : 9'h08C);
        pw(8'h11, 8'h01);
        rd(8'h11, fq ? 9'h015 : 9'h02A);
        report_and_stop();
    end
endmodule // tb_oscillator_control_status
`default_nettype wire
